// ==== src/mlf_defs.vh ====
/*
 Constants for the motor lock and position-detect fault block.
 Assumes a 125 MHz core clock; times are converted to cycles here.
*/
`ifndef MLF_DEFS_VH
`define MLF_DEFS_VH
`define MLF_CLK_HZ 125000000
`define MLF_NO_MOTOR_MS 500
`define MLF_NO_MOTOR_CYC ((`MLF_CLK_HZ / 1000) * `MLF_NO_MOTOR_MS)
`define MLF_TMR_BITS 12
`define MLF_STARTUP_IPD 2'h2
`define MLF_RATE_10M_DIV 14'h000D
`define MLF_RATE_1M_DIV 14'h007D
`define MLF_RATE_100K_DIV 14'h04E2
`define MLF_RATE_10K_DIV 14'h30D4
`define MLF_MODE_LATCH 2'h0
`define MLF_MODE_RETRY 2'h1
`define MLF_GATE_OFF 2'h0
`define MLF_GATE_RECIRC 2'h1
`define MLF_GATE_HS_ON 2'h2
`define MLF_GATE_LS_ON 2'h3
`define MLF_RETRY_DEF_CYC 125000000
`endif

// ==== src/mlf_lock_fault.v ====
/*
 Motor lock detection, parameter-measurement faults and position-detect
 timer faults with lock response handling.
 Assumes all analog-derived values come from logic on the same clock;
 only the regulator-ready level comes from outside and is synchronised.
*/
`timescale 1ns/1ps
`include "mlf_defs.vh"

module mlf_lock_fault #(
	parameter SPD_W = 16,
	parameter NO_MOTOR_CYC = `MLF_NO_MOTOR_CYC,
	parameter RETRY_W = 32,
	parameter TMR_W = `MLF_TMR_BITS, // Ramp timer width; shrink only to speed up tests
	parameter [13:0] RATE0_DIV = `MLF_RATE_10M_DIV, // Clock cycles per 10 MHz tick
	parameter [13:0] RATE1_DIV = `MLF_RATE_1M_DIV, // Clock cycles per 1 MHz tick
	parameter [13:0] RATE2_DIV = `MLF_RATE_100K_DIV, // Clock cycles per 100 kHz tick
	parameter [13:0] RATE3_DIV = `MLF_RATE_10K_DIV // Clock cycles per 10 kHz tick
) (
	input wire clk,
	input wire arst_n,
	input wire regulator_ready,
	input wire overspeed_lock_event_lock_enable,
	input wire bemf_mismatch_lock_event_lock_enable,
	input wire no_motor_lock_enable,
	input wire [SPD_W-1:0] measured_speed,
	input wire [SPD_W-1:0] overspeed_threshold,
	input wire [SPD_W-1:0] bemf_estimated,
	input wire [SPD_W-1:0] bemf_expected,
	input wire [SPD_W-1:0] bemf_mismatch_threshold,
	input wire [SPD_W-1:0] phase_a_current,
	input wire [SPD_W-1:0] phase_b_current,
	input wire [SPD_W-1:0] phase_c_current,
	input wire [SPD_W-1:0] missing_motor_current_threshold,
	input wire [3:0] lock_response_mode,
	input wire [RETRY_W-1:0] lock_retry_time,
	input wire alarm_pin_disable,
	input wire fault_clear_command,
	input wire resist_induct_meas_active,
	input wire bemf_const_meas_active,
	input wire [SPD_W-1:0] measured_bemf,
	input wire [SPD_W-1:0] stationary_detect_threshold,
	input wire [1:0] startup_method_select,
	input wire pulse_start,
	input wire ramp_current_reached,
	input wire ramp_current_zero,
	input wire position_timeout_fault_enable,
	input wire position_pulse_rate_fault_enable,
	output reg overspeed_lock_event_ff,
	output reg bemf_mismatch_lock_event_ff,
	output reg missing_motor_event_ff,
	output reg motor_lock_flag_ff,
	output reg controller_fault_ff,
	output reg param_meas_ramp_fault_ff,
	output reg param_meas_bemf_fault_ff,
	output reg position_ramp_timeout_fault_ff,
	output reg position_decay_timeout_fault_ff,
	output reg position_pulse_rate_fault_ff,
	output reg gate_hold_ff,
	output reg [1:0] gate_state_ff,
	output reg fault_out_n_ff
);
	// Ramp phase states, one-hot
	localparam ST_IDLE = 3'b001;
	localparam ST_UP = 3'b010;
	localparam ST_DOWN = 3'b100;
	localparam [TMR_W-1:0] TMR_MAX = {TMR_W{1'b1}};

	reg reg_meta_ff; // First synchroniser stage
	reg reg_sync_ff; // Regulator ready, synchronised
	reg [31:0] low_cnt_ff; // Low-current duration counter
	reg [2:0] st_ff; // Ramp phase
	reg [1:0] rate_ff; // Timer rate index, 0 = 10 MHz
	reg [13:0] div_ff; // Rate divider
	reg [TMR_W-1:0] tmr_ff; // Ramp timer, 12 bits by default
	reg [RETRY_W-1:0] retry_cnt_ff; // Retry time counter
	reg retry_run_ff; // Retry timing in progress
	reg [13:0] div_top; // Current divider length
	wire tick; // Timer enable pulse
	wire ovf; // Timer overflow this cycle
	wire ipd_mode; // Position detect selected
	wire any_low; // A phase below threshold
	wire ev_spd, ev_bemf, ev_nomtr, lock_ev;
	wire mode_act; // Protective modes
	wire mode_rep; // Report only
	wire [SPD_W-1:0] bemf_gap;

	// Divider length per fallback rate
	always @* begin
		case (rate_ff)
			2'h0: div_top = RATE0_DIV;
			2'h1: div_top = RATE1_DIV;
			2'h2: div_top = RATE2_DIV;
			default: div_top = RATE3_DIV;
		endcase
	end

	assign tick = (div_ff == div_top - 14'h0001);
	assign ovf = tick && (tmr_ff == TMR_MAX);
	assign ipd_mode = (startup_method_select == `MLF_STARTUP_IPD);
	assign any_low = (phase_a_current < missing_motor_current_threshold) ||
		(phase_b_current < missing_motor_current_threshold) ||
		(phase_c_current < missing_motor_current_threshold);
	assign bemf_gap = (bemf_estimated > bemf_expected) ? bemf_estimated - bemf_expected :
		bemf_expected - bemf_estimated;
	assign ev_spd = overspeed_lock_event_lock_enable && (measured_speed > overspeed_threshold);
	assign ev_bemf = bemf_mismatch_lock_event_lock_enable && (bemf_gap > bemf_mismatch_threshold);
	assign ev_nomtr = no_motor_lock_enable && any_low &&
		(low_cnt_ff >= NO_MOTOR_CYC - 1);
	assign lock_ev = ev_spd || ev_bemf || ev_nomtr;
	// Disabled is 1xx1; every 1xx0, 1000 included, is treated as report only
	assign mode_act = !lock_response_mode[3];
	assign mode_rep = lock_response_mode[3] && !lock_response_mode[0];

	// Regulator-ready synchroniser
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_meta_ff <= 1'b0;
			reg_sync_ff <= 1'b0;
		end else begin
			reg_meta_ff <= regulator_ready;
			reg_sync_ff <= reg_meta_ff;
		end
	end

	// Continuous low-current timer, restarts when all phases recover
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			low_cnt_ff <= 32'h00000000;
		end else if (!any_low || !no_motor_lock_enable) begin
			low_cnt_ff <= 32'h00000000;
		end else if (low_cnt_ff < NO_MOTOR_CYC) begin
			low_cnt_ff <= low_cnt_ff + 32'h00000001;
		end
	end

	// Ramp-up / ramp-down timer with stepped rate fallback
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= ST_IDLE;
			rate_ff <= 2'h0;
			div_ff <= 14'h0000;
			tmr_ff <= {TMR_W{1'b0}};
		end else begin
			div_ff <= tick ? 14'h0000 : div_ff + 14'h0001;
			if (tick) begin
				tmr_ff <= tmr_ff + 1'b1;
			end
			case (st_ff)
				ST_IDLE: begin
					if (pulse_start && (ipd_mode || resist_induct_meas_active)) begin
						st_ff <= ST_UP;
						rate_ff <= 2'h0;
						div_ff <= 14'h0000;
						tmr_ff <= {TMR_W{1'b0}};
					end
				end
				ST_UP: begin
					if (ramp_current_reached) begin
						st_ff <= ST_DOWN;
						rate_ff <= 2'h0;
						div_ff <= 14'h0000;
						tmr_ff <= {TMR_W{1'b0}};
					end else if (ovf) begin
						// Slower clock retry; give up after the slowest
						if (rate_ff == 2'h3) begin
							st_ff <= ST_IDLE;
						end
						rate_ff <= rate_ff + 2'h1;
						tmr_ff <= {TMR_W{1'b0}};
					end
				end
				ST_DOWN: begin
					if (ramp_current_zero) begin
						st_ff <= ST_IDLE;
					end else if (pulse_start) begin
						// Next pulse before decay: restart ramp
						st_ff <= ST_UP;
						rate_ff <= 2'h0;
						tmr_ff <= {TMR_W{1'b0}};
					end else if (ovf) begin
						if (rate_ff == 2'h3) begin
							st_ff <= ST_IDLE;
						end
						rate_ff <= rate_ff + 2'h1;
						tmr_ff <= {TMR_W{1'b0}};
					end
				end
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

	// Fault flags, lock response and retry; a new event wins over a clear
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			overspeed_lock_event_ff <= 1'b0;
			bemf_mismatch_lock_event_ff <= 1'b0;
			missing_motor_event_ff <= 1'b0;
			motor_lock_flag_ff <= 1'b0;
			controller_fault_ff <= 1'b0;
			param_meas_ramp_fault_ff <= 1'b0;
			param_meas_bemf_fault_ff <= 1'b0;
			position_ramp_timeout_fault_ff <= 1'b0;
			position_decay_timeout_fault_ff <= 1'b0;
			position_pulse_rate_fault_ff <= 1'b0;
			gate_hold_ff <= 1'b0;
			gate_state_ff <= `MLF_GATE_OFF;
			fault_out_n_ff <= 1'b0;
			retry_cnt_ff <= {RETRY_W{1'b0}};
			retry_run_ff <= 1'b0;
		end else begin
			// The clear command drops lock flags only once the cause has gone and no retry is running
			if (fault_clear_command && !lock_ev && !retry_run_ff) begin
				overspeed_lock_event_ff <= 1'b0;
				bemf_mismatch_lock_event_ff <= 1'b0;
				missing_motor_event_ff <= 1'b0;
				motor_lock_flag_ff <= 1'b0;
				controller_fault_ff <= 1'b0;
				gate_hold_ff <= 1'b0;
			end
			if (fault_clear_command) begin
				param_meas_ramp_fault_ff <= 1'b0;
				param_meas_bemf_fault_ff <= 1'b0;
				position_ramp_timeout_fault_ff <= 1'b0;
				position_decay_timeout_fault_ff <= 1'b0;
				position_pulse_rate_fault_ff <= 1'b0;
			end
			// Retry countdown: resume and drop lock flags at expiry
			if (retry_run_ff) begin
				if (retry_cnt_ff >= lock_retry_time) begin
					retry_run_ff <= 1'b0;
					gate_hold_ff <= 1'b0;
					overspeed_lock_event_ff <= 1'b0;
					bemf_mismatch_lock_event_ff <= 1'b0;
					missing_motor_event_ff <= 1'b0;
					motor_lock_flag_ff <= 1'b0;
					controller_fault_ff <= 1'b0;
				end else begin
					retry_cnt_ff <= retry_cnt_ff + 1'b1;
				end
			end
			if (lock_ev && (mode_act || mode_rep) && !retry_run_ff) begin
				controller_fault_ff <= 1'b1;
				motor_lock_flag_ff <= 1'b1;
				if (ev_spd) overspeed_lock_event_ff <= 1'b1;
				if (ev_bemf) bemf_mismatch_lock_event_ff <= 1'b1;
				if (ev_nomtr) missing_motor_event_ff <= 1'b1;
				if (mode_act) begin
					gate_hold_ff <= 1'b1;
					gate_state_ff <= lock_response_mode[1:0];
					if (lock_response_mode[3:2] == `MLF_MODE_RETRY) begin
						retry_run_ff <= 1'b1;
						retry_cnt_ff <= {RETRY_W{1'b0}};
					end
				end
			end
			if (resist_induct_meas_active && st_ff == ST_UP && ovf && rate_ff == 2'h3) begin
				param_meas_ramp_fault_ff <= 1'b1;
			end
			if (bemf_const_meas_active && measured_bemf < stationary_detect_threshold) begin
				param_meas_bemf_fault_ff <= 1'b1;
			end
			if (position_timeout_fault_enable && ipd_mode && ovf && rate_ff == 2'h3) begin
				if (st_ff == ST_UP) position_ramp_timeout_fault_ff <= 1'b1;
				if (st_ff == ST_DOWN) position_decay_timeout_fault_ff <= 1'b1;
			end
			if (position_pulse_rate_fault_enable && st_ff == ST_DOWN && pulse_start &&
				!ramp_current_zero) begin
				position_pulse_rate_fault_ff <= 1'b1;
			end
			// Fault pin: low until regulators up, then on held or reported fault
			fault_out_n_ff <= reg_sync_ff && !(gate_hold_ff ||
				(controller_fault_ff && !alarm_pin_disable));
		end
	end
endmodule // mlf_lock_fault

// ==== test/mlf_lock_fault_asserts.sv ====
/* Port checker for the lock fault block.
 Assumes it is bound onto mlf_lock_fault. */
`timescale 1ns/1ps
module mlf_lock_fault_asserts #(
	parameter SPD_W = 16
) (
	input wire clk,
	input wire arst_n,
	input wire regulator_ready,
	input wire overspeed_lock_event_lock_enable,
	input wire bemf_mismatch_lock_event_lock_enable,
	input wire [SPD_W-1:0] measured_speed,
	input wire [SPD_W-1:0] overspeed_threshold,
	input wire [3:0] lock_response_mode,
	input wire pulse_start,
	input wire position_pulse_rate_fault_enable,
	input wire overspeed_lock_event_ff,
	input wire bemf_mismatch_lock_event_ff,
	input wire motor_lock_flag_ff,
	input wire controller_fault_ff,
	input wire position_pulse_rate_fault_ff,
	input wire gate_hold_ff,
	input wire [1:0] gate_state_ff,
	input wire fault_out_n_ff
);
	// One clock domain, so one default
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_SPD: assert property ($rose(overspeed_lock_event_ff) |->
		$past(overspeed_lock_event_lock_enable && measured_speed > overspeed_threshold)) else $error("overspeed");
	AST_BEMF_EN: assert property ($rose(bemf_mismatch_lock_event_ff) |->
		$past(bemf_mismatch_lock_event_lock_enable)) else $error("bemf event while off");
	AST_FLAGS: assert property ($rose(bemf_mismatch_lock_event_ff) |->
		motor_lock_flag_ff && controller_fault_ff) else $error("lock flags missing");
	AST_DIS: assert property ($past(lock_response_mode[3] && lock_response_mode[0]) |->
		!$rose(motor_lock_flag_ff)) else $error("lock in disabled mode");
	AST_GATE: assert property ($rose(gate_hold_ff) |->
		gate_state_ff == $past(lock_response_mode[1:0]) && !$past(lock_response_mode[3]))
		else $error("gate state wrong");
	AST_FOUT: assert property ($rose(gate_hold_ff) |=> !fault_out_n_ff)
		else $error("fault pin not low");
	AST_REG: assert property (!$past(regulator_ready, 3) |-> !fault_out_n_ff)
		else $error("fault pin released early");
	AST_RATE: assert property ($rose(position_pulse_rate_fault_ff) |->
		$past(position_pulse_rate_fault_enable && pulse_start)) else $error("rate fault");
endmodule // mlf_lock_fault_asserts
bind mlf_lock_fault mlf_lock_fault_asserts #(.SPD_W(SPD_W)) u_chk (.clk(clk), .arst_n(arst_n),
	.regulator_ready(regulator_ready), .overspeed_lock_event_lock_enable(overspeed_lock_event_lock_enable),
	.bemf_mismatch_lock_event_lock_enable(bemf_mismatch_lock_event_lock_enable), .measured_speed(measured_speed),
	.overspeed_threshold(overspeed_threshold), .lock_response_mode(lock_response_mode),
	.pulse_start(pulse_start), .position_pulse_rate_fault_enable(position_pulse_rate_fault_enable),
	.overspeed_lock_event_ff(overspeed_lock_event_ff), .gate_hold_ff(gate_hold_ff),
	.bemf_mismatch_lock_event_ff(bemf_mismatch_lock_event_ff), .gate_state_ff(gate_state_ff),
	.motor_lock_flag_ff(motor_lock_flag_ff), .controller_fault_ff(controller_fault_ff),
	.position_pulse_rate_fault_ff(position_pulse_rate_fault_ff), .fault_out_n_ff(fault_out_n_ff));

// ==== test/mlf_motor_model.sv ====
/* Motor winding seen through the power stage.
 Assumes the bench clock; current rises only while driven. */
`timescale 1ns/1ps
module mlf_motor_model (
	input wire clk,
	input wire connected,
	input wire ramp_up,
	output wire [15:0] phase_current,
	output wire reached,
	output wire decayed
);
	reg [5:0] cur_ff = 6'h00; // Winding current
	// Decay is slow, so a fast next pulse finds current left
	always @(posedge clk) begin
		if (ramp_up && connected) begin
			// Held at the current limit while driven, so it never wraps to zero
			if (cur_ff != 6'h3F) cur_ff <= cur_ff + 6'h01;
		end else if (cur_ff != 6'h00) begin
			cur_ff <= cur_ff - 6'h01;
		end
	end
	assign reached = cur_ff >= 6'h10;
	assign decayed = cur_ff == 6'h00;
	// Open phases read no current
	assign phase_current = connected ? 16'h0200 : 16'h0000;
endmodule // mlf_motor_model

// ==== test/mlf_lock_fault_bench.sv ====
/* Self-checking bench for the lock fault block.
 Assumes src/ on the include path and the motor model. */
`timescale 1ns/1ps
module mlf_lock_fault_bench;
	localparam NM = 50; // Short no-motor time
	reg clk = 1'b0, arst_n = 1'b0, rdy = 1'b0, spe = 1'b1, nme = 1'b0, clr = 1'b0;
	reg meas = 1'b0, ps = 1'b0, up = 1'b0, conn = 1'b1, pe = 1'b1, rim = 1'b0, bme = 1'b1;
	reg [15:0] spd = 16'h0010, bem = 16'h0000, mb = 16'h0200, thr = 16'h0100;
	reg [3:0] mode = 4'h0;
	reg [1:0] sms = 2'h0;
	wire [15:0] ic;
	wire rc, rz, ov, bm, nm, ml, cf, pb, pf, gh, fo, pr, pt, pd;
	wire [1:0] gs;
	integer n_errors = 0, compares = 0, i;
	// Free-running 8 ns clock
	always #4 clk = ~clk;
	mlf_motor_model i_mlf_motor_model (.clk(clk), .connected(conn), .ramp_up(up),
		.phase_current(ic), .reached(rc), .decayed(rz));
	// Short timer and dividers keep each fallback run to a few dozen cycles
	mlf_lock_fault #(.NO_MOTOR_CYC(NM), .TMR_W(2), .RATE0_DIV(14'h0002), .RATE1_DIV(14'h0003),
		.RATE2_DIV(14'h0004), .RATE3_DIV(14'h0005)) i_mlf_lock_fault (.clk(clk), .arst_n(arst_n),
		.regulator_ready(rdy), .overspeed_lock_event_lock_enable(spe), .bemf_mismatch_lock_event_lock_enable(bme),
		.no_motor_lock_enable(nme), .measured_speed(spd), .overspeed_threshold(thr),
		.bemf_estimated(bem), .bemf_expected(16'h0000), .bemf_mismatch_threshold(thr),
		.phase_a_current(ic), .phase_b_current(ic), .phase_c_current(ic),
		.missing_motor_current_threshold(thr), .lock_response_mode(mode),
		.lock_retry_time(32'h00000014), .alarm_pin_disable(1'b0), .fault_clear_command(clr),
		.resist_induct_meas_active(rim), .bemf_const_meas_active(meas), .measured_bemf(mb),
		.stationary_detect_threshold(thr), .startup_method_select(sms), .pulse_start(ps),
		.ramp_current_reached(rc), .ramp_current_zero(rz), .position_timeout_fault_enable(pe),
		.position_pulse_rate_fault_enable(pe), .overspeed_lock_event_ff(ov),
		.bemf_mismatch_lock_event_ff(bm), .missing_motor_event_ff(nm), .motor_lock_flag_ff(ml),
		.controller_fault_ff(cf), .param_meas_ramp_fault_ff(pr), .param_meas_bemf_fault_ff(pb),
		.position_ramp_timeout_fault_ff(pt), .position_decay_timeout_fault_ff(pd),
		.position_pulse_rate_fault_ff(pf), .gate_hold_ff(gh), .gate_state_ff(gs),
		.fault_out_n_ff(fo));
	// Wait n edges, then let their updates land
	task e(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input [15:0] exp, input [15:0] got, input [8*5-1:0] nam);
		compares = compares + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("[ERR] %s exp %h got %h", nam, exp, got);
		end
	endtask
	// Clear pulse of one cycle
	task clear;
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
	endtask
	// Trip the back-EMF detector in mode m, then remove cause and clear
	task trip(input [3:0] m, input lk, input hd, input fe);
		@(posedge clk) begin mode <= m; bem <= 16'h0300; end
		e(3);
		chk(lk, ml, "lock");
		chk(hd, gh, "hold");
		chk(fe, fo, "fout");
		if (hd) chk(m[1:0], gs, "gate");
		@(posedge clk) bem <= 16'h0000;
		clear;
		e(3);
		chk(0, ml, "lock");
	endtask
	task end_of_test;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Hang guard, far above the few hundred cycles used
	initial begin
		repeat (20000) @(posedge clk);
		n_errors = n_errors + 1;
		end_of_test;
	end
	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		e(4);
		chk(0, fo, "fout");
		@(posedge clk) rdy <= 1'b1;
		e(5);
		chk(1, fo, "fout");
		@(posedge clk) begin mode <= 4'h2; spd <= 16'h0200; end
		e(3);
		chk(1, ov, "spd");
		chk(1, cf, "ctrl");
		chk(2, gs, "gate");
		clear;
		e(2);
		chk(1, ov, "spd");
		@(posedge clk) spd <= 16'h0010;
		clear;
		e(3);
		chk(0, ov, "spd");
		chk(1, fo, "fout");
		// Both detectors off while both causes stand
		@(posedge clk) begin spe <= 1'b0; bme <= 1'b0; spd <= 16'h0200; bem <= 16'h0300; end
		e(4);
		chk(0, ml, "lock");
		@(posedge clk) begin spe <= 1'b1; bme <= 1'b1; spd <= 16'h0010; bem <= 16'h0000; end
		for (i = 0; i < 4; i = i + 1) trip(i[3:0], 1'b1, 1'b1, 1'b0);
		trip(4'h8, 1'b1, 1'b0, 1'b0);
		trip(4'h9, 1'b0, 1'b0, 1'b1);
		trip(4'hD, 1'b0, 1'b0, 1'b1);
		// Retry mode: cause lasts one cycle only
		@(posedge clk) begin mode <= 4'h6; spd <= 16'h0200; end
		@(posedge clk) spd <= 16'h0010;
		e(10);
		chk(1, ml, "lock");
		e(20);
		chk(0, ml, "lock");
		chk(1, fo, "fout");
		@(posedge clk) begin mode <= 4'h0; conn <= 1'b0; nme <= 1'b1; end
		e(NM - 5);
		chk(0, nm, "nomtr");
		e(10);
		chk(1, nm, "nomtr");
		@(posedge clk) conn <= 1'b1;
		clear;
		@(posedge clk) meas <= 1'b1;
		e(3);
		chk(0, pb, "mbemf");
		@(posedge clk) mb <= 16'h0010;
		e(3);
		chk(1, pb, "mbemf");
		@(posedge clk) begin meas <= 1'b0; mb <= 16'h0200; end
		clear;
		@(posedge clk) begin sms <= 2'h2; ps <= 1'b1; up <= 1'b1; end
		@(posedge clk) ps <= 1'b0;
		// Poll every cycle until the model current reaches the threshold
		for (i = 0; i < 100 && !rc; i = i + 1) e(1);
		@(posedge clk) begin up <= 1'b0; ps <= 1'b1; end
		@(posedge clk) ps <= 1'b0;
		e(3);
		chk(1, pf, "rate");
		e(20);
		// Current never ramps: measurement fault only, position fault masked
		@(posedge clk) begin rim <= 1'b1; pe <= 1'b0; ps <= 1'b1; end
		@(posedge clk) ps <= 1'b0;
		e(50);
		chk(0, pr, "mramp");
		e(10);
		chk(1, pr, "mramp");
		chk(0, pt, "pramp");
		clear;
		@(posedge clk) begin rim <= 1'b0; pe <= 1'b1; ps <= 1'b1; end
		@(posedge clk) ps <= 1'b0;
		e(60);
		chk(1, pt, "pramp");
		chk(0, pr, "mramp");
		// Winding kept driven, so the decay never completes
		@(posedge clk) begin ps <= 1'b1; up <= 1'b1; end
		@(posedge clk) ps <= 1'b0;
		e(60);
		chk(0, pd, "decay");
		e(20);
		chk(1, pd, "decay");
		@(posedge clk) up <= 1'b0;
		end_of_test;
	end
endmodule // mlf_lock_fault_bench
